// ### include/wpr_pkg.sv
// Shared constants and types for the wiper register serial port and its controller.
package wpr_pkg;

   // ----------------------------------------------------------------------
   // Target addresses and wiper register
   // ----------------------------------------------------------------------
   localparam logic [6:0] WPR_ADDR_OPT0 = 7'h2E;  // Single-address build and first alternative.
   localparam logic [6:0] WPR_ADDR_OPT1 = 7'h17;  // Second alternative address.
   localparam logic [6:0] WPR_ADDR_OPT2 = 7'h16;  // Third alternative address.
   localparam logic [6:0] WPR_WIPER_RESET = 7'h40;  // Midscale, code 64.

   // ----------------------------------------------------------------------
   // Bit counting within a nine-clock byte
   // ----------------------------------------------------------------------
   localparam logic [3:0] WPR_BIT_LAST = 4'h7;  // Index of the eighth data bit.
   localparam logic [3:0] WPR_BIT_ACK = 4'h8;  // Index of the acknowledge clock.
   localparam logic [3:0] WPR_BIT_FIRST = 4'h1;  // Bit count after the first sampled address bit.

   // ----------------------------------------------------------------------
   // Controller timing
   // ----------------------------------------------------------------------
   localparam int WPR_SYS_PERIOD_NS = 20;
   localparam int WPR_SCL_QUARTER_NS = 625;
   localparam logic [5:0] WPR_SCL_QUARTER_CYC =
      6'((WPR_SCL_QUARTER_NS + WPR_SYS_PERIOD_NS - 1) / WPR_SYS_PERIOD_NS);

   // ----------------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {DEV_IDLE, DEV_ADDR, DEV_WRITE, DEV_READ} wpr_dev_state_t;
   typedef enum logic [2:0] {CTL_IDLE, CTL_START, CTL_BIT, CTL_STOP} wpr_ctl_state_t;

endpackage

// ### include/wpr_link_if.sv
// Two-wire link between the wiper register port and its bus controller.
`timescale 1ns/10ps
interface wpr_link_if;
   logic scl;
   logic ctl_sda_out;
   logic ctl_sda_oe;
   logic dev_sda_out;
   logic dev_sda_oe;
   logic sda;

   // Open-drain data line with a pull-up: any enabled driver showing low pulls it low.
   assign sda = ~((ctl_sda_oe & ~ctl_sda_out) | (dev_sda_oe & ~dev_sda_out));

   modport ctl (output scl, output ctl_sda_out, output ctl_sda_oe, input sda);
   modport dev (input scl, input sda, output dev_sda_out, output dev_sda_oe);
endinterface

// ### src/wpr_port.sv
// Serial target port holding the 7-bit wiper position register.
`timescale 1ns/10ps
// How it works
// - Start condition begins address reception.
// - Address byte: seven address bits, then direction.
// - Matching address acknowledged low on ninth clock.
// - Mismatch: stay idle, drive nothing, keep wiper.
// - Own address is a build-time parameter.
// - Write data byte: eight bits plus device acknowledge.
// - Change data only while the clock is low.
// - Read: shift wiper byte out, ninth is controller's.
// - Stop condition returns the port to idle.
// - Write stop: controller releases data in tenth clock.
// - Read: controller not-acknowledges, then stops.
// - Every written byte loads wiper and is acknowledged.
// - Reads repeat while the controller acknowledges.
// - New direction needs a new start and address.
// - Only seven wiper bits are stored.
// - Wiper presets to midscale at power-on.
module wpr_port
   import wpr_pkg::*;
#(
   parameter logic [6:0] TARGET_ADDR = WPR_ADDR_OPT0
) (
   // System clock and reset.
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   // Link to the bus controller.
   wpr_link_if.dev link,
   // Wiper value and status in the system clock domain.
   output logic [6:0] wiper_position_out,
   output logic wiper_update_out,
   output logic bus_busy_out
);

   // ----------------------------------------------------------------------
   // Link-domain state
   // ----------------------------------------------------------------------
   wpr_dev_state_t state;
   logic [3:0] bit_cnt;
   logic [7:0] rx_shift;
   logic [7:0] tx_byte;
   logic dir_read;
   logic ack_slot;
   logic [6:0] wiper_position_register;
   logic upd_tgl;
   logic start_tgl;
   logic stop_tgl;
   logic start_seen;
   logic stop_seen;
   logic sda_oe;
   logic start_pend;
   logic stop_pend;

   // ----------------------------------------------------------------------
   // System-domain crossing state
   // ----------------------------------------------------------------------
   logic upd_s1;
   logic upd_s2;
   logic upd_s3;
   logic start_s1;
   logic start_s2;
   logic start_s3;
   logic stop_s1;
   logic stop_s2;
   logic stop_s3;

   // Selects one bit of the outgoing byte, most significant first.
   function automatic logic tx_bit(input logic [7:0] data, input logic [3:0] idx);
      tx_bit = data[3'd7 - idx[2:0]];
   endfunction

   // ----------------------------------------------------------------------
   // Start and stop detection on data edges while the clock is high
   // ----------------------------------------------------------------------

   // A falling data edge with the clock high marks a start.
   always_ff @(negedge link.sda or negedge arst_n_in) begin
      if (!arst_n_in) begin
         start_tgl <= 1'b0;
      end else if (link.scl) begin
         start_tgl <= ~start_tgl;
      end
   end

   // A rising data edge with the clock high marks a stop.
   always_ff @(posedge link.sda or negedge arst_n_in) begin
      if (!arst_n_in) begin
         stop_tgl <= 1'b0;
      end else if (link.scl) begin
         stop_tgl <= ~stop_tgl;
      end
   end

   // The toggles settle a full clock-low phase before the next rising clock edge.
   assign start_pend = start_tgl ^ start_seen;
   assign stop_pend = stop_tgl ^ stop_seen;

   // ----------------------------------------------------------------------
   // Receive side: sample data on rising clock edges
   // ----------------------------------------------------------------------

   // Byte sequencer for address, write and read phases.
   always_ff @(posedge link.scl or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= DEV_IDLE;
         bit_cnt <= 4'h0;
         rx_shift <= 8'h00;
         tx_byte <= 8'h00;
         dir_read <= 1'b0;
         ack_slot <= 1'b0;
         start_seen <= 1'b0;
         stop_seen <= 1'b0;
      end else if (start_pend) begin
         // A start, even mid-transfer, restarts address reception with this first bit.
         start_seen <= start_tgl;
         stop_seen <= stop_tgl;
         state <= DEV_ADDR;
         bit_cnt <= WPR_BIT_FIRST;
         rx_shift <= {7'h00, link.sda};
         ack_slot <= 1'b0;
      end else if (stop_pend) begin
         stop_seen <= stop_tgl;
         state <= DEV_IDLE;
         ack_slot <= 1'b0;
      end else begin
         case (state)
            DEV_ADDR: begin
               if (bit_cnt == WPR_BIT_LAST) begin
                  // Seven address bits, then the direction bit just sampled.
                  if (rx_shift[6:0] == TARGET_ADDR) begin
                     dir_read <= link.sda;
                     ack_slot <= 1'b1;
                     bit_cnt <= WPR_BIT_ACK;
                  end else begin
                     state <= DEV_IDLE;
                  end
               end else if (bit_cnt == WPR_BIT_ACK) begin
                  ack_slot <= 1'b0;
                  bit_cnt <= 4'h0;
                  tx_byte <= {1'b0, wiper_position_register};
                  state <= dir_read ? DEV_READ : DEV_WRITE;
               end else begin
                  rx_shift <= {rx_shift[6:0], link.sda};
                  bit_cnt <= bit_cnt + 4'h1;
               end
            end
            DEV_WRITE: begin
               if (bit_cnt == WPR_BIT_LAST) begin
                  ack_slot <= 1'b1;
                  bit_cnt <= WPR_BIT_ACK;
               end else if (bit_cnt == WPR_BIT_ACK) begin
                  ack_slot <= 1'b0;
                  bit_cnt <= 4'h0;
               end else begin
                  rx_shift <= {rx_shift[6:0], link.sda};
                  bit_cnt <= bit_cnt + 4'h1;
               end
            end
            DEV_READ: begin
               if (bit_cnt == WPR_BIT_ACK) begin
                  if (link.sda) begin
                     state <= DEV_IDLE;
                  end else begin
                     bit_cnt <= 4'h0;
                     tx_byte <= {1'b0, wiper_position_register};
                  end
               end else begin
                  bit_cnt <= bit_cnt + 4'h1;
               end
            end
            default: begin
               bit_cnt <= 4'h0;
            end
         endcase
      end
   end

   // Wiper register: loaded from the low seven bits of each completed write byte.
   always_ff @(posedge link.scl or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wiper_position_register <= WPR_WIPER_RESET;
         upd_tgl <= 1'b0;
      end else if (!start_pend && !stop_pend && state == DEV_WRITE && bit_cnt == WPR_BIT_LAST) begin
         wiper_position_register <= {rx_shift[5:0], link.sda};
         upd_tgl <= ~upd_tgl;
      end
   end

   // ----------------------------------------------------------------------
   // Transmit side: change data only on falling clock edges
   // ----------------------------------------------------------------------

   // Pulls data low for acknowledges and for zero bits of the read byte.
   always_ff @(negedge link.scl or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sda_oe <= 1'b0;
      end else begin
         sda_oe <= ack_slot
            | (state == DEV_READ && bit_cnt < WPR_BIT_ACK && !tx_bit(tx_byte, bit_cnt));
      end
   end

   assign link.dev_sda_oe = sda_oe;
   assign link.dev_sda_out = 1'b0;

   // ----------------------------------------------------------------------
   // Crossing into the system clock domain
   // ----------------------------------------------------------------------

   // Two-flop synchronisers for the update, start and stop toggles, plus an edge stage.
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         upd_s1 <= 1'b0;
         upd_s2 <= 1'b0;
         upd_s3 <= 1'b0;
         start_s1 <= 1'b0;
         start_s2 <= 1'b0;
         start_s3 <= 1'b0;
         stop_s1 <= 1'b0;
         stop_s2 <= 1'b0;
         stop_s3 <= 1'b0;
      end else begin
         upd_s1 <= upd_tgl;
         upd_s2 <= upd_s1;
         upd_s3 <= upd_s2;
         start_s1 <= start_tgl;
         start_s2 <= start_s1;
         start_s3 <= start_s2;
         stop_s1 <= stop_tgl;
         stop_s2 <= stop_s1;
         stop_s3 <= stop_s2;
      end
   end

   // The link register is stable for many link clocks after each toggle, so it is captured whole.
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         wiper_position_out <= WPR_WIPER_RESET;
         wiper_update_out <= 1'b0;
      end else begin
         wiper_update_out <= upd_s2 ^ upd_s3;
         if (upd_s2 ^ upd_s3) begin
            wiper_position_out <= wiper_position_register;
         end
      end
   end

   // Busy between a start and a stop; a start seen together with a stop wins.
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         bus_busy_out <= 1'b0;
      end else if (start_s2 ^ start_s3) begin
         bus_busy_out <= 1'b1;
      end else if (stop_s2 ^ stop_s3) begin
         bus_busy_out <= 1'b0;
      end
   end

endmodule // wpr_port

// ### src/wpr_ctl.sv
// Bus controller that drives the clock and runs write and read transfers to the wiper port.
`timescale 1ns/10ps
module wpr_ctl
   import wpr_pkg::*;
(
   // System clock and reset.
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   // Command request.
   input wire logic cmd_valid_in,
   output logic cmd_ready_out,
   input wire logic cmd_read_in,
   input wire logic [6:0] cmd_addr_in,
   input wire logic [7:0] cmd_data_in,
   input wire logic [2:0] cmd_len_in,
   // Results.
   output logic [7:0] rd_data_out,
   output logic rd_valid_out,
   output logic done_out,
   output logic nack_out,
   // Link to the wiper port.
   wpr_link_if.ctl link
);

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   wpr_ctl_state_t state;
   logic [5:0] qcnt;
   logic tick;
   logic [1:0] ph;
   logic [3:0] bit_cnt;
   logic [8:0] shift;
   logic [7:0] rx;
   logic ack_bit;
   logic first_byte;
   logic is_read;
   logic [7:0] wdata;
   logic [2:0] left;
   logic scl;
   logic sda_oe;
   logic sda_s1;
   logic sda_s2;

   // Nine-clock frame for a read byte: released data bits, then ack unless last.
   function automatic logic [8:0] read_frame(input logic [2:0] remaining);
      read_frame = {8'hFF, remaining == 3'h1};
   endfunction

   // Data line synchroniser.
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
      end else begin
         sda_s1 <= link.sda;
         sda_s2 <= sda_s1;
      end
   end

   // Quarter-period divider that paces the generated clock.
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         qcnt <= 6'h00;
      end else if (state == CTL_IDLE || tick) begin
         qcnt <= 6'h00;
      end else begin
         qcnt <= qcnt + 6'h01;
      end
   end

   assign tick = (qcnt == WPR_SCL_QUARTER_CYC - 6'h01);
   assign cmd_ready_out = (state == CTL_IDLE);

   // ----------------------------------------------------------------------
   // Transfer sequencer
   // ----------------------------------------------------------------------

   // Start, nine-clock bytes and stop; within bytes, data moves only while the clock is low.
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         state <= CTL_IDLE;
         ph <= 2'h0;
         bit_cnt <= 4'h0;
         shift <= 9'h1FF;
         rx <= 8'h00;
         ack_bit <= 1'b1;
         first_byte <= 1'b0;
         is_read <= 1'b0;
         wdata <= 8'h00;
         left <= 3'h1;
         scl <= 1'b1;
         sda_oe <= 1'b0;
         rd_data_out <= 8'h00;
         rd_valid_out <= 1'b0;
         done_out <= 1'b0;
         nack_out <= 1'b0;
      end else begin
         rd_valid_out <= 1'b0;
         done_out <= 1'b0;
         case (state)
            CTL_IDLE: begin
               scl <= 1'b1;
               sda_oe <= 1'b0;
               if (cmd_valid_in) begin
                  state <= CTL_START;
                  ph <= 2'h0;
                  is_read <= cmd_read_in;
                  wdata <= cmd_data_in;
                  left <= (cmd_len_in == 3'h0) ? 3'h1 : cmd_len_in;
                  shift <= {cmd_addr_in, cmd_read_in, 1'b1};
                  nack_out <= 1'b0;
               end
            end
            CTL_START: begin
               if (tick) begin
                  if (ph == 2'h0) begin
                     sda_oe <= 1'b1;
                     ph <= 2'h1;
                  end else if (ph == 2'h1) begin
                     // The clock falls a quarter before the first bit, so data never moves with the clock edge.
                     scl <= 1'b0;
                     ph <= 2'h2;
                  end else begin
                     sda_oe <= ~shift[8];
                     first_byte <= 1'b1;
                     bit_cnt <= 4'h0;
                     ph <= 2'h0;
                     state <= CTL_BIT;
                  end
               end
            end
            CTL_BIT: begin
               if (tick) begin
                  ph <= ph + 2'h1;
                  if (ph == 2'h0) begin
                     scl <= 1'b1;
                  end else if (ph == 2'h2) begin
                     scl <= 1'b0;
                     if (bit_cnt == WPR_BIT_ACK) begin
                        ack_bit <= sda_s2;
                     end else begin
                        rx <= {rx[6:0], sda_s2};
                     end
                  end else if (ph == 2'h3) begin
                     if (bit_cnt != WPR_BIT_ACK) begin
                        bit_cnt <= bit_cnt + 4'h1;
                        shift <= {shift[7:0], 1'b1};
                        sda_oe <= ~shift[7];
                     end else begin
                        bit_cnt <= 4'h0;
                        first_byte <= 1'b0;
                        if (first_byte && ack_bit) begin
                           nack_out <= 1'b1;
                           sda_oe <= 1'b1;
                           state <= CTL_STOP;
                        end else if (first_byte) begin
                           shift <= is_read ? read_frame(left) : {wdata, 1'b1};
                           sda_oe <= is_read ? 1'b0 : ~wdata[7];
                        end else begin
                           if (is_read) begin
                              rd_data_out <= rx;
                              rd_valid_out <= 1'b1;
                           end else if (ack_bit) begin
                              nack_out <= 1'b1;
                           end
                           if (left == 3'h1 || (!is_read && ack_bit)) begin
                              sda_oe <= 1'b1;
                              state <= CTL_STOP;
                           end else begin
                              left <= left - 3'h1;
                              shift <= is_read ? read_frame(left - 3'h1) : {wdata, 1'b1};
                              sda_oe <= is_read ? 1'b0 : ~wdata[7];
                           end
                        end
                     end
                  end
               end
            end
            CTL_STOP: begin
               if (tick) begin
                  ph <= ph + 2'h1;
                  if (ph == 2'h0) begin
                     scl <= 1'b1;
                  end else if (ph == 2'h1) begin
                     sda_oe <= 1'b0;
                  end else begin
                     done_out <= 1'b1;
                     state <= CTL_IDLE;
                  end
               end
            end
            default: begin
               state <= CTL_IDLE;
            end
         endcase
      end
   end

   assign link.scl = scl;
   assign link.ctl_sda_oe = sda_oe;
   assign link.ctl_sda_out = 1'b0;

endmodule // wpr_ctl

// ### sim/wpr_link_chk.sv
// Link checker for the wire between the bus controller and the wiper port.
`timescale 1ns/10ps
module wpr_link_chk
   import wpr_pkg::*;
#(
   parameter logic [6:0] TARGET_ADDR = WPR_ADDR_OPT0
) (
   // System clock and reset.
   input wire logic sys_clk_in,
   input wire logic arst_n_in,
   // Link wires.
   input wire logic scl,
   input wire logic sda,
   input wire logic dev_sda_oe
);
   logic scl_q, sda_q, inxfer, first, match, rdm;
   logic [3:0] bitn;
   logic [6:0] sh;
   wire rise = scl & ~scl_q;
   wire start = scl & scl_q & sda_q & ~sda;
   wire stop = scl & scl_q & ~sda_q & sda;

   // ----
   // Frame tracking
   // ----
   // Oversamples the wires and counts clock rises within each nine-clock byte.
   always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         inxfer <= 1'b0;
         first <= 1'b0;
         match <= 1'b0;
         rdm <= 1'b0;
         bitn <= 4'h0;
         sh <= 7'h00;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
         if (start) begin
            inxfer <= 1'b1;
            first <= 1'b1;
            match <= 1'b0;
            bitn <= 4'h0;
         end else if (stop) begin
            inxfer <= 1'b0;
         end else if (rise) begin
            sh <= {sh[5:0], sda};
            bitn <= (bitn == 4'h8) ? 4'h0 : bitn + 4'h1;
            if (bitn == 4'h7 && first) begin
               match <= (sh == TARGET_ADDR);
               rdm <= sda;
            end
            if (bitn == 4'h8) begin
               first <= 1'b0;
            end
         end
      end
   end

   // ----
   // Properties
   // ----
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!arst_n_in);

   dev_edge_a: assert property ($changed(dev_sda_oe) |-> !scl)
      else $error("device drive changed with clock high");
   addr_quiet_a: assert property (rise && first && bitn < 4'h8 |-> !dev_sda_oe)
      else $error("device drove during address bits");
   addr_ack_a: assert property (rise && first && bitn == 4'h8 && match |-> !sda [*3])
      else $error("address not acknowledged");
   idle_quiet_a: assert property (!inxfer || (!first && !match) |-> !dev_sda_oe)
      else $error("device drove while idle or unaddressed");
   wr_quiet_a: assert property (rise && !first && match && !rdm && bitn < 4'h8 |-> !dev_sda_oe)
      else $error("device drove during written data");
   wr_ack_a: assert property (rise && !first && match && !rdm && bitn == 4'h8 |-> !sda)
      else $error("data byte not acknowledged");
   rd_msb_a: assert property (rise && !first && match && rdm && bitn == 4'h0 |-> !sda)
      else $error("read byte top bit not zero");
   rd_rel_a: assert property (rise && !first && match && rdm && bitn == 4'h8 |-> !dev_sda_oe)
      else $error("device held data in controller slot");

   // Main scenarios reached on the link.
   cover property (rise && first && bitn == 4'h8 && match && rdm);
   cover property (rise && !first && match && !rdm && bitn == 4'h8);
   cover property (inxfer && !first && !match);
endmodule // wpr_link_chk

// ### sim/i2c_wiper_register_port_tb.sv
// Self-checking bench for the wiper register port and its bus controller.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
   $display("ERROR %s exp %h seen %h", nm, e, g); end end
module i2c_wiper_register_port_tb;
   import wpr_pkg::*;
   logic sys_clk_in = 1'b0;
   logic arst_n_in = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_read = 1'b0;
   logic [6:0] cmd_addr = 7'h00;
   logic [7:0] cmd_data = 8'h00;
   logic [2:0] cmd_len = 3'h0;
   logic cmd_ready, rd_valid, done, nack, upd, busy, busy_b;
   logic [7:0] rd_data;
   logic [6:0] wiper, wiper_b, exp_w;
   logic [31:0] seed = 32'hA92D8C81;
   int bad_count = 0;
   int checked = 0;
   wpr_link_if link();
   wpr_link_if link_b();

   // Controller and port face each other; a second port is bit-banged by the bench.
   wpr_ctl wpr_ctl_inst (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .cmd_valid_in(cmd_valid),
      .cmd_ready_out(cmd_ready), .cmd_read_in(cmd_read), .cmd_addr_in(cmd_addr), .cmd_data_in(cmd_data),
      .cmd_len_in(cmd_len), .rd_data_out(rd_data), .rd_valid_out(rd_valid), .done_out(done),
      .nack_out(nack), .link(link));
   wpr_port wpr_port_inst (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .link(link),
      .wiper_position_out(wiper), .wiper_update_out(upd), .bus_busy_out(busy));
   wpr_port #(.TARGET_ADDR(WPR_ADDR_OPT1)) wpr_port_b_inst (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
      .link(link_b), .wiper_position_out(wiper_b), .wiper_update_out(), .bus_busy_out(busy_b));
   wpr_link_chk #(.TARGET_ADDR(WPR_ADDR_OPT0)) wpr_link_chk_inst (.sys_clk_in(sys_clk_in),
      .arst_n_in(arst_n_in), .scl(link.scl), .sda(link.sda), .dev_sda_oe(link.dev_sda_oe));

   // System clock.
   initial begin
      forever #10 sys_clk_in = ~sys_clk_in;
   end

   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Expected read byte for a given wiper value.
   function automatic logic [7:0] rd_byte(input logic [6:0] w);
      return {1'b0, w};
   endfunction

   task automatic give_verdict();
      if (bad_count == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Runs one command through the controller and checks its outcome.
   task automatic do_cmd(input logic rd, input logic [6:0] a, input logic [7:0] d, input logic [2:0] n);
      int i;
      int ups;
      int rds;
      int nb;
      logic own;
      logic bz;
      ups = 0;
      bz = 1'b0;
      rds = 0;
      own = (a == WPR_ADDR_OPT0);
      nb = (n == 3'h0) ? 1 : int'(n);
      @(posedge sys_clk_in);
      #1;
      cmd_read = rd;
      cmd_addr = a;
      cmd_data = d;
      cmd_len = n;
      cmd_valid = 1'b1;
      `CHK("cmd_ready", 1'b1, cmd_ready)
      @(posedge sys_clk_in);
      #1;
      cmd_valid = 1'b0;
      for (i = 0; i < 20000 && done !== 1'b1; i++) begin
         @(posedge sys_clk_in);
         #1;
         ups += int'(upd === 1'b1);
         bz = bz | (busy === 1'b1);
         if (rd_valid === 1'b1) begin
            rds++;
            `CHK("rd_data", rd_byte(exp_w), rd_data)
         end
      end
      if (i >= 20000) begin
         bad_count++;
         give_verdict();
      end
      if (!rd && own) exp_w = d[6:0];
      `CHK("nack", !own, nack)
      `CHK("updates", (!rd && own) ? nb : 0, ups)
      `CHK("reads", (rd && own) ? nb : 0, rds)
      `CHK("wiper", exp_w, wiper)
      `CHK("busy", 1'b0, busy)
      `CHK("busy_seen", 1'b1, bz)
   endtask

   // Bench-made link clock of 30 ns for the second port: one bit, sampling the wire mid-high.
   task automatic bb_bit(input logic b, output logic s);
      link_b.ctl_sda_oe = !b;
      #7.5 link_b.scl = 1'b1;
      #7.5 s = link_b.sda;
      #7.5 link_b.scl = 1'b0;
      #7.5;
   endtask

   // Start when stop is low, stop when it is high.
   task automatic bb_edge(input logic stop);
      link_b.ctl_sda_oe = stop;
      #7.5 link_b.scl = 1'b1;
      #7.5 link_b.ctl_sda_oe = !stop;
      #7.5 link_b.scl = stop;
      #7.5;
   endtask

   // Sends the top nb bits of a byte and, when whole, reads the acknowledge slot.
   task automatic bb_byte(input logic [7:0] v, input int nb, output logic ack);
      logic s;
      for (int i = 7; i > 7 - nb; i--) bb_bit(v[i], s);
      if (nb == 8) bb_bit(1'b1, ack);
   endtask

   // Main sequence.
   initial begin
      logic [31:0] r;
      logic [7:0] d;
      logic ack;
      link_b.scl = 1'b1;
      link_b.ctl_sda_out = 1'b0;
      link_b.ctl_sda_oe = 1'b0;
      exp_w = 7'h40;
      // Reset falls after time zero so that every asynchronous flop, link side included, sees its edge.
      #1;
      arst_n_in = 1'b0;
      repeat (5) @(posedge sys_clk_in);
      #1;
      arst_n_in = 1'b1;
      `CHK("wiper_rst", 7'h40, wiper)
      `CHK("wiper_b_rst", 7'h40, wiper_b)
      do_cmd(1'b1, WPR_ADDR_OPT0, 8'h00, 3'h1);
      do_cmd(1'b0, WPR_ADDR_OPT0, 8'hFF, 3'h0);
      do_cmd(1'b1, WPR_ADDR_OPT0, 8'h00, 3'h3);
      do_cmd(1'b0, WPR_ADDR_OPT1, 8'h15, 3'h2);
      do_cmd(1'b1, WPR_ADDR_OPT2, 8'h00, 3'h1);
      do_cmd(1'b0, WPR_ADDR_OPT0, 8'h00, 3'h3);
      for (int k = 0; k < 6; k++) begin
         r = rnd();
         do_cmd(r[0], (r[3:1] == 3'h0) ? WPR_ADDR_OPT2 : WPR_ADDR_OPT0, r[15:8], r[18:16]);
      end
      // Restarts in mid-address and mid-data, then an address for another device.
      #3;
      d = 8'(rnd());
      bb_edge(1'b0);
      bb_byte({WPR_ADDR_OPT1, 1'b0}, 4, ack);
      bb_edge(1'b0);
      bb_byte({WPR_ADDR_OPT1, 1'b0}, 8, ack);
      `CHK("ack_b", 1'b0, ack)
      bb_byte(d, 8, ack);
      `CHK("ack_d", 1'b0, ack)
      bb_byte(~d, 3, ack);
      bb_edge(1'b0);
      bb_byte({WPR_ADDR_OPT2, 1'b0}, 8, ack);
      `CHK("ack_x", 1'b1, ack)
      bb_byte(~d, 8, ack);
      `CHK("ack_y", 1'b1, ack)
      bb_edge(1'b1);
      repeat (10) @(posedge sys_clk_in);
      #1;
      `CHK("wiper_b", d[6:0], wiper_b)
      `CHK("busy_b", 1'b0, busy_b)
      give_verdict();
   end
endmodule // i2c_wiper_register_port_tb
